// file: design/css_cfg.svh
// Constants of the controller scan sequencer
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH
`define CSS_NBITS 64
`define CSS_AW 6
`define CSS_NX 16
`define CSS_X_LO 0
`define CSS_XR_LO 16
`define CSS_Y_LO 32
`define CSS_C_LO 48
`define CSS_RUNGS 64
`define CSS_LAST_RUNG 6'h3F
`define CSS_NLOOPS 8
`define CSS_LAST_LOOP 3'h7
`define CSS_SW_PROG 2'h0
`define CSS_SW_TERM 2'h1
`define CSS_SW_RUN 2'h2
`define CSS_SVC_LAST 4'h3
`define CSS_NSR 4
`define CSS_CLK_PERIOD_NS 50
`define CSS_RTC_PERIOD_NS 1000000000
`endif

// file: design/css_pkg.sv
// Types shared by the scan sequencer modules
`include "css_cfg.svh"
package css_pkg;
	typedef enum logic {md_prog, md_run} css_mode_t;
	typedef enum logic [3:0] {
		st_inputs, st_special, st_service, st_bus_rd, st_bus_wr, st_clock, st_solve, st_loops, st_write
	} css_seg_t;
	typedef enum logic [1:0] {op_end, op_and, op_or, op_andn} css_op_t;
	typedef struct packed {
		css_op_t op;
		logic imm;
		logic [`CSS_AW-1:0] src_a;
		logic [`CSS_AW-1:0] src_b;
		logic [`CSS_AW-1:0] dst;
	} css_rung_t;
	typedef struct packed {
		logic en;
		logic [`CSS_AW-1:0] addr;
		logic val;
	} css_bitwr_t;
endpackage

// file: design/css_scan.sv
// Scan-cycle sequencer top: modes, image register, forcing and scan segments
// What this block does
// RL1 - In run mode solve ladder each scan, then write outputs.
// RL2 - After solve, run only configured loops, then write outputs.
// RL3 - Non-fatal error is reported; mode stays unchanged.
// RL4 - Fatal error forces program mode and all outputs off.
// RL5 - Program mode runs no program and refreshes no outputs.
// RL6 - Program mode holds outputs off; outputs update only in run.
// RL7 - Inputs are sampled every scan in both modes.
// RL8 - Mode follows switch; in terminal position a programmer commands it.
// RL9 - During run-mode edits outputs hold their last state.
// RL10 - Edit found faulty: outputs off and program mode.
// RL11 - Scan starts by storing input points in the image register.
// RL12 - Immediate reads take module state directly, image untouched.
// RL13 - After local inputs, take specialty and remote input data.
// RL14 - Remote data taken from link master when it offers it during the specialty segment.
// RL15 - After inputs, service peripherals and accept status changes.
// RL16 - Regular force lasts until the bit is next written.
// RL17 - Overridden bit is not changed by input update or solve.
// RL18 - Forcing still changes an overridden bit and it sticks.
// RL19 - Backplane read and write segment, local base modules only.
// RL20 - Clock and special relays refreshed every scan.
// RL21 - Solve rung by rung from first until end coil.
// RL22 - Solve result overwrites a forced output.
// RL23 - Forced output not written by program keeps its force.
// RL24 - Forces applied after input read, before the same scan's solve.
`timescale 1ns/1ps
module css_scan import css_pkg::*; #(
	parameter int RTC_DIV = `CSS_RTC_PERIOD_NS / `CSS_CLK_PERIOD_NS
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [`CSS_NX-1:0] in_points_in,
	input wire logic [1:0] mode_switch_in,
	input wire logic remote_valid_in,
	input wire logic [15:0] remote_data_in,
	input wire logic pm_req_in,
	input wire logic pm_run_in,
	input wire css_bitwr_t force_in,
	input wire css_bitwr_t ovr_in,
	output logic periph_ack_out,
	input wire logic prog_we_in,
	input wire logic [`CSS_AW-1:0] prog_addr_in,
	input wire css_rung_t prog_data_in,
	input wire logic edit_active_in,
	input wire logic edit_err_in,
	input wire logic fatal_err_in,
	input wire logic nonfatal_err_in,
	input wire logic err_clr_in,
	input wire logic bus_local_in,
	output logic bus_req_out,
	output logic bus_we_out,
	input wire logic bus_done_in,
	input wire logic [15:0] bus_rdata_in,
	output logic [15:0] bus_wdata_out,
	input wire logic [`CSS_NLOOPS-1:0] loop_cfg_in,
	output logic loop_req_out,
	output logic [2:0] loop_idx_out,
	input wire logic loop_done_in,
	output logic [15:0] out_points_out,
	output logic run_mode_out,
	output logic err_nonfatal_out,
	output logic err_fatal_out,
	output logic [`CSS_NSR-1:0] special_relay_out,
	output logic [31:0] rtc_out,
	output logic [`CSS_NBITS-1:0] image_out,
	output css_seg_t seg_out
);
	////////////////////////////////////////////////////////////////////////////
	logic [`CSS_NX-1:0] in_sync;
	logic [1:0] sw_sync;
	logic [1:0] sw_prev;
	css_mode_t mode;
	css_mode_t next_mode;
	css_seg_t next_seg;
	logic fault_lock;
	logic next_lock;
	logic fatal_hit;
	logic term_cmd;
	logic want_run;
	logic sw_changed;
	logic first_scan;
	logic [3:0] svc_cnt;
	logic svc_last;
	logic in_run_seg;
	logic abort_run;
	logic solve_start;
	logic solve_done;
	logic [`CSS_AW-1:0] solve_pc;
	css_bitwr_t solve_wr;
	css_rung_t prog_mem [0:`CSS_RUNGS-1];
	logic [`CSS_NBITS-1:0] ovr_bits;
	logic [`CSS_NBITS-1:0] upd_src;
	logic [`CSS_NBITS-1:0] upd_mask;
	logic [`CSS_NBITS-1:0] solve_hot;
	logic [`CSS_NBITS-1:0] force_hot;
	logic [`CSS_NBITS-1:0] ovr_hot;
	logic [`CSS_NBITS-1:0] next_image;
	logic force_take;
	logic ovr_take;
	logic x_take;
	logic xr_take;
	logic c_take;
	logic loop_hit;
	logic loop_adv;
	logic out_off;
	logic out_load;
	logic [31:0] rtc_div;
	logic [31:0] rtc_sec;

	function automatic logic [`CSS_NBITS-1:0] bit_hot(input logic en, input logic [`CSS_AW-1:0] a);
		bit_hot = en ? (64'h0000000000000001 << a) : 64'h0000000000000000;
	endfunction

	css_sync3 #(.W(`CSS_NX)) u_in_sync (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.async_in(in_points_in),
		.sync_out(in_sync)
	);

	css_sync3 #(.W(2)) u_sw_sync (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.async_in(mode_switch_in),
		.sync_out(sw_sync)
	);

	css_solve u_solve (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.start_in(solve_start),
		.abort_in(abort_run),
		.image_in(image_out),
		.raw_in(in_sync),
		.rung_in(prog_mem[solve_pc]),
		.pc_out(solve_pc),
		.wr_out(solve_wr),
		.done_out(solve_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode selection
	assign fatal_hit = fatal_err_in | edit_err_in;
	assign sw_changed = (sw_sync != sw_prev);
	// RL8 - terminal position commands
	assign term_cmd = (sw_sync == `CSS_SW_TERM) && pm_req_in;
	assign want_run = (sw_sync == `CSS_SW_RUN) ? 1'h1 :
		(sw_sync == `CSS_SW_TERM) ? (term_cmd ? pm_run_in : (mode == md_run)) : 1'h0;
	// RL4 - fatal locks out run
	assign next_lock = fatal_hit | (fault_lock & ~(sw_changed | (term_cmd & pm_run_in)));
	// RL10 - edit fault forces program
	assign next_mode = (want_run && !next_lock) ? md_run : md_prog;
	assign run_mode_out = (mode == md_run);

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			mode <= md_prog;
			fault_lock <= 1'h0;
			sw_prev <= `CSS_SW_PROG;
		end else begin
			mode <= next_mode;
			fault_lock <= next_lock;
			sw_prev <= sw_sync;
		end
	end

	// RL3 - sticky error report
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			err_nonfatal_out <= 1'h0;
			err_fatal_out <= 1'h0;
		end else begin
			err_nonfatal_out <= nonfatal_err_in | (err_nonfatal_out & ~err_clr_in);
			err_fatal_out <= fatal_hit | (err_fatal_out & ~err_clr_in);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scan segment sequencing
	assign svc_last = (svc_cnt == `CSS_SVC_LAST);
	assign in_run_seg = (seg_out == st_solve) || (seg_out == st_loops) || (seg_out == st_write);
	assign abort_run = in_run_seg && (next_mode == md_prog);
	// RL5 - solve only in run
	assign solve_start = (seg_out == st_clock) && (mode == md_run) && (next_mode == md_run);
	assign loop_hit = loop_cfg_in[loop_idx_out];
	assign loop_adv = (seg_out == st_loops) && (!loop_hit || loop_done_in);
	// RL2 - configured loops only
	assign loop_req_out = (seg_out == st_loops) && loop_hit;
	// RL19 - local base bus transfers
	assign bus_req_out = ((seg_out == st_bus_rd) || (seg_out == st_bus_wr)) && bus_local_in;
	assign bus_we_out = (seg_out == st_bus_wr);
	// RL15 - peripheral service window
	assign periph_ack_out = (seg_out == st_service);

	always_comb begin
		next_seg = seg_out;
		case (seg_out)
			// RL7 - inputs read every scan
			st_inputs: next_seg = st_special;
			// RL13 - specialty after local inputs
			st_special: next_seg = st_service;
			st_service: if (svc_last) next_seg = bus_local_in ? st_bus_rd : st_clock;
			st_bus_rd: if (!bus_local_in) next_seg = st_clock; else if (bus_done_in) next_seg = st_bus_wr;
			st_bus_wr: if (!bus_local_in || bus_done_in) next_seg = st_clock;
			st_clock: next_seg = solve_start ? st_solve : st_inputs;
			st_solve: if (solve_done) next_seg = st_loops;
			// RL2 - loops before output write
			st_loops: if (loop_adv && loop_idx_out == `CSS_LAST_LOOP) next_seg = st_write;
			st_write: next_seg = st_inputs;
			default: next_seg = st_inputs;
		endcase
		if (abort_run) begin
			next_seg = st_inputs;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			seg_out <= st_inputs;
			svc_cnt <= 4'h0;
			loop_idx_out <= 3'h0;
		end else begin
			seg_out <= next_seg;
			svc_cnt <= (seg_out == st_service) ? svc_cnt + 4'h1 : 4'h0;
			loop_idx_out <= (seg_out != st_loops) ? 3'h0 : (loop_adv ? loop_idx_out + 3'h1 : loop_idx_out);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Program store, written by the programming device
	always_ff @(posedge ref_clk_in) begin
		if (prog_we_in) begin
			prog_mem[prog_addr_in] <= prog_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Image register
	// RL11 - local input capture
	assign x_take = (seg_out == st_inputs);
	// RL14 - remote data when offered
	assign xr_take = (seg_out == st_special) && remote_valid_in;
	assign c_take = (seg_out == st_bus_rd) && bus_local_in && bus_done_in;
	assign upd_src = {bus_rdata_in, 16'h0000, remote_data_in, in_sync};
	// RL17 - override blocks updates
	assign upd_mask = {{16{c_take}}, 16'h0000, {16{xr_take}}, {16{x_take}}} & ~ovr_bits;
	// RL22 - solve overwrites force
	assign solve_hot = bit_hot(solve_wr.en, solve_wr.addr) & ~ovr_bits;
	// RL24 - forces taken before solve
	assign force_take = periph_ack_out && force_in.en;
	assign ovr_take = periph_ack_out && ovr_in.en;
	// RL18 - force ignores override
	assign force_hot = bit_hot(force_take, force_in.addr);
	assign ovr_hot = bit_hot(ovr_take, ovr_in.addr);
	// RL16 - force kept until rewritten
	assign next_image = (image_out & ~upd_mask & ~solve_hot & ~force_hot) | (upd_src & upd_mask) |
		({`CSS_NBITS{solve_wr.val}} & solve_hot) | ({`CSS_NBITS{force_in.val}} & force_hot);

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			image_out <= '0;
			ovr_bits <= '0;
		end else begin
			image_out <= next_image;
			ovr_bits <= ovr_in.val ? (ovr_bits | ovr_hot) : (ovr_bits & ~ovr_hot);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			bus_wdata_out <= 16'h0000;
		end else if (c_take) begin
			bus_wdata_out <= next_image[`CSS_C_LO+15:`CSS_C_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output write
	// RL6 - outputs off outside run
	assign out_off = (mode == md_prog) | fatal_hit;
	// RL9 - hold during edits
	assign out_load = (seg_out == st_write) && !edit_active_in;

	// RL1 - write output image
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || out_off) begin
			out_points_out <= 16'h0000;
		end else if (out_load) begin
			// RL23 - unwritten forces pass through
			out_points_out <= image_out[`CSS_Y_LO+15:`CSS_Y_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock and special relays
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			rtc_div <= 32'h00000000;
			rtc_sec <= 32'h00000000;
		end else if (rtc_div == 32'(RTC_DIV - 1)) begin
			rtc_div <= 32'h00000000;
			rtc_sec <= rtc_sec + 32'h00000001;
		end else begin
			rtc_div <= rtc_div + 32'h00000001;
		end
	end

	// RL20 - refresh clock and relays
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			rtc_out <= 32'h00000000;
			special_relay_out <= '0;
			first_scan <= 1'h0;
		end else begin
			first_scan <= ((mode == md_prog) && (next_mode == md_run)) | (first_scan & (seg_out != st_write));
			if (seg_out == st_clock) begin
				rtc_out <= rtc_sec;
				special_relay_out <= {fault_lock, err_nonfatal_out, mode == md_run, first_scan};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_prog_out_off: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL6
		(mode == md_prog) |=> (out_points_out == 16'h0000)) else $error("outputs on in program mode");
	a_fatal_to_prog: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL4
		fatal_err_in |=> (mode == md_prog) && (out_points_out == 16'h0000) && fault_lock)
		else $error("fatal error did not stop run");
	a_edit_err_off: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL10
		edit_err_in |=> (mode == md_prog) && (out_points_out == 16'h0000)) else $error("edit fault ignored");
	a_edit_hold: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL9
		(edit_active_in && mode == md_run && !fatal_hit) |=> $stable(out_points_out))
		else $error("outputs moved during edit");
	a_nonfatal_stay: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL3
		(nonfatal_err_in && next_mode == mode) |=> $stable(mode) && err_nonfatal_out)
		else $error("non-fatal error mishandled");
	a_loops_cfg_only: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL2
		(seg_out == st_loops && !loop_cfg_in[loop_idx_out] && !abort_run) |-> !loop_req_out ##1
		(loop_idx_out == $past(loop_idx_out) + 3'h1)) else $error("unconfigured loop run");
	a_solve_to_loops: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL2
		(seg_out == st_solve && solve_done && !abort_run) |=> (seg_out == st_loops))
		else $error("loops not right after solve");
	a_prog_no_solve: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL5
		(mode == md_prog) |-> !solve_start && (seg_out != st_solve || abort_run)) else $error("solve in program mode");
	a_scan_order: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL13
		(seg_out == st_inputs) |=> (seg_out == st_special) ##1 (seg_out == st_service))
		else $error("scan order broken");
	a_input_sample: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL11
		(seg_out == st_inputs && !ovr_bits[0]) |=> (image_out[0] == $past(in_sync[0])))
		else $error("input not captured");
	a_ovr_hold: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL17
		(seg_out == st_inputs) |=> ((image_out[15:0] ^ $past(image_out[15:0])) & $past(ovr_bits[15:0])) == 16'h0000)
		else $error("override bit changed");
	a_force_take: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL18
		(force_take && force_in.addr == 6'h00) |=> (image_out[0] == $past(force_in.val)))
		else $error("force not applied");
endmodule

// file: design/css_solve.sv
// Ladder solver, one rung per clock
`timescale 1ns/1ps
module css_solve import css_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic [`CSS_NBITS-1:0] image_in,
	input wire logic [`CSS_NX-1:0] raw_in,
	input wire css_rung_t rung_in,
	output logic [`CSS_AW-1:0] pc_out,
	output css_bitwr_t wr_out,
	output logic done_out
);
	logic busy;
	logic bit_a;
	logic bit_b;
	logic res;
	logic is_end;

	function automatic logic pick(input logic imm, input logic [`CSS_AW-1:0] a,
		input logic [`CSS_NBITS-1:0] img, input logic [`CSS_NX-1:0] raw);
		// RL12 - immediate module read
		pick = (imm && a < `CSS_AW'(`CSS_NX)) ? raw[a[3:0]] : img[a];
	endfunction

	assign bit_a = pick(rung_in.imm, rung_in.src_a, image_in, raw_in);
	assign bit_b = pick(rung_in.imm, rung_in.src_b, image_in, raw_in);
	assign is_end = (rung_in.op == op_end);
	assign res = (rung_in.op == op_and) ? (bit_a & bit_b) :
		(rung_in.op == op_or) ? (bit_a | bit_b) : (bit_a & ~bit_b);
	assign wr_out = {busy & ~is_end, rung_in.dst, res};
	// RL21 - stop at end coil
	assign done_out = busy && (is_end || pc_out == `CSS_LAST_RUNG);

	// RL21 - rungs in order
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || abort_in) begin
			busy <= 1'h0;
			pc_out <= '0;
		end else if (start_in) begin
			busy <= 1'h1;
			pc_out <= '0;
		end else if (done_out) begin
			busy <= 1'h0;
		end else if (busy) begin
			pc_out <= pc_out + `CSS_AW'(1);
		end
	end
endmodule

// file: design/css_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module css_sync3 #(
	parameter int W = 1
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge ref_clk_in) begin
				if (!nrst_in) begin
					s1 <= 1'h0;
					s2 <= 1'h0;
					s3 <= 1'h0;
					sync_out[i] <= 1'h0;
				end else begin
					s1 <= async_in[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						sync_out[i] <= s3;
					end
				end
			end
		end
	endgenerate
endmodule

// file: sim/controller_scan_sequencer_tb.sv
// Self-checking bench of the scan sequencer
`timescale 1ns/1ps
`include "css_cfg.svh"
module controller_scan_sequencer_tb import css_pkg::*;;
	localparam logic [15:0] RDATA = 16'h5AC3;
	localparam logic [15:0] REMOTE = 16'h3C96;
	logic ref_clk_in = 1'b0, nrst_in = 1'b0;
	logic [15:0] in_points_in = 16'h0000;
	logic [1:0] mode_switch_in = `CSS_SW_PROG;
	logic remote_valid_in, bus_done_in, loop_done_in, bad;
	logic [15:0] remote_data_in, bus_rdata_in, bus_wdata_out, out_points_out;
	logic pm_req_in = 1'b0, pm_run_in = 1'b0, prog_we_in = 1'b0, edit_active_in = 1'b0;
	logic edit_err_in = 1'b0, fatal_err_in = 1'b0, nonfatal_err_in = 1'b0, err_clr_in = 1'b0;
	logic bus_local_in = 1'b1, seen_clr = 1'b0;
	css_bitwr_t force_in = '0, ovr_in = '0;
	logic [5:0] prog_addr_in = 6'h00;
	css_rung_t prog_data_in = '0;
	logic [7:0] loop_cfg_in = 8'h05, seen = 8'h00;
	logic [3:0] delay = 4'h0, special_relay_out;
	logic periph_ack_out, bus_req_out, bus_we_out, loop_req_out;
	logic run_mode_out, err_nonfatal_out, err_fatal_out;
	logic [2:0] loop_idx_out;
	logic [31:0] rtc_out, r;
	logic [63:0] image_out;
	css_seg_t seg_out;
	int n_fail = 0, comparisons = 0;

	css_scan #(.RTC_DIV(20)) i_dut (.ref_clk_in, .nrst_in, .in_points_in, .mode_switch_in,
		.remote_valid_in, .remote_data_in, .pm_req_in, .pm_run_in, .force_in, .ovr_in, .periph_ack_out,
		.prog_we_in, .prog_addr_in, .prog_data_in, .edit_active_in, .edit_err_in, .fatal_err_in,
		.nonfatal_err_in, .err_clr_in, .bus_local_in, .bus_req_out, .bus_we_out, .bus_done_in,
		.bus_rdata_in, .bus_wdata_out, .loop_cfg_in, .loop_req_out, .loop_idx_out, .loop_done_in,
		.out_points_out, .run_mode_out, .err_nonfatal_out, .err_fatal_out, .special_relay_out,
		.rtc_out, .image_out, .seg_out);
	css_io_model #(.RDATA(RDATA), .REMOTE(REMOTE)) i_io (.ref_clk_in, .seg_in(seg_out),
		.bus_req_in(bus_req_out), .bus_we_in(bus_we_out), .loop_req_in(loop_req_out), .delay_in(delay),
		.remote_valid_out(remote_valid_in), .remote_data_out(remote_data_in),
		.bus_done_out(bus_done_in), .bus_rdata_out(bus_rdata_in), .loop_done_out(loop_done_in));

	always #25 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		if (seen_clr)
			seen <= 8'h00;
		else if (loop_req_out && loop_done_in)
			seen[loop_idx_out] <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wait_seg(input css_seg_t s);
		for (int i = 0; i < 400 && seg_out !== s; i++)
			@(negedge ref_clk_in);
		if (seg_out !== s)
			chk("seg_wait", s, seg_out);
	endtask
	task automatic scan_end(input int n);
		repeat (n) begin
			wait_seg(st_write);
			wait_seg(st_inputs);
		end
	endtask
	task automatic put(input logic o, input logic [5:0] a, input logic v);
		wait_seg(st_service);
		chk("periph_ack", 1'b1, periph_ack_out);
		ovr_in = o ? css_bitwr_t'{1'b1, a, v} : css_bitwr_t'('0);
		force_in = o ? css_bitwr_t'('0) : css_bitwr_t'{1'b1, a, v};
		@(negedge ref_clk_in);
	endtask
	task automatic rel;
		ovr_in = '0;
		force_in = '0;
	endtask
	task automatic hit(input logic [4:0] m);
		{pm_req_in, nonfatal_err_in, err_clr_in, fatal_err_in, edit_err_in} = m;
		@(negedge ref_clk_in);
		{pm_req_in, nonfatal_err_in, err_clr_in, fatal_err_in, edit_err_in} = 5'h00;
		repeat (3) @(negedge ref_clk_in);
	endtask
	task automatic set_sw(input logic [1:0] v);
		mode_switch_in = v;
		repeat (10) @(negedge ref_clk_in);
	endtask
	task automatic ld(input logic [5:0] a, input css_rung_t rg);
		prog_we_in = 1'b1;
		prog_addr_in = a;
		prog_data_in = rg;
		@(negedge ref_clk_in);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_prog;
		in_points_in = 16'hA5C3;
		bad = 1'b0;
		repeat (60) begin
			@(negedge ref_clk_in);
			bad = bad | (seg_out === st_solve) | (out_points_out !== 16'h0000);
		end
		chk("prog_idle", 1'b0, bad);
		chk("x_local", 16'hA5C3, image_out[15:0]);
		chk("x_remote", REMOTE, image_out[31:16]);
		chk("bus_read", RDATA, image_out[63:48]);
		ld(6'h00, '{op_and, 1'b0, 6'h00, 6'h00, 6'h20});
		ld(6'h01, '{op_and, 1'b1, 6'h04, 6'h04, 6'h22});
		ld(6'h02, '{op_and, 1'b0, 6'h04, 6'h04, 6'h23});
		ld(6'h03, '{op_end, 1'b0, 6'h00, 6'h00, 6'h00});
		prog_we_in = 1'b0;
		$display("test prog done");
	endtask
	task automatic t_run;
		in_points_in = 16'h0001;
		delay = 4'h3;
		set_sw(`CSS_SW_RUN);
		chk("run_mode", 1'b1, run_mode_out);
		scan_end(1);
		seen_clr = 1'b1;
		wait_seg(st_bus_wr);
		seen_clr = 1'b0;
		chk("bus_wdata", RDATA, bus_wdata_out);
		chk("bus_we", 1'b1, bus_we_out);
		scan_end(1);
		chk("out_low", 4'h1, out_points_out[3:0]);
		chk("loops", 8'h05, seen);
		chk("run_relay", 1'b1, special_relay_out[1]);
		r = rtc_out;
		loop_cfg_in = 8'h82;
		seen_clr = 1'b1;
		wait_seg(st_service);
		seen_clr = 1'b0;
		scan_end(1);
		chk("loops_alt", 8'h82, seen);
		scan_end(3);
		chk("rtc_step", 1'b1, rtc_out > r);
		$display("test run done");
	endtask
	task automatic t_force;
		put(1'b0, 6'h25, 1'b1);
		put(1'b0, 6'h00, 1'b0);
		put(1'b0, 6'h06, 1'b1);
		rel;
		chk("x6_forced", 1'b1, image_out[6]);
		scan_end(1);
		chk("y0_same_scan", 1'b0, out_points_out[0]);
		chk("y5_kept", 1'b1, out_points_out[5]);
		wait_seg(st_service);
		chk("x6_rewritten", 1'b0, image_out[6]);
		put(1'b0, 6'h20, 1'b0);
		rel;
		scan_end(1);
		chk("y0_solved", 1'b1, out_points_out[0]);
		chk("y5_still", 1'b1, out_points_out[5]);
		$display("test force done");
	endtask
	task automatic t_ovr;
		put(1'b1, 6'h04, 1'b1);
		rel;
		in_points_in = 16'h0011;
		scan_end(2);
		chk("x4_held", 1'b0, image_out[4]);
		chk("imm_vs_img", 2'h1, out_points_out[3:2]);
		put(1'b0, 6'h04, 1'b1);
		rel;
		in_points_in = 16'h0001;
		scan_end(2);
		chk("x4_forced", 1'b1, image_out[4]);
		put(1'b1, 6'h04, 1'b0);
		rel;
		scan_end(2);
		chk("x4_free", 1'b0, image_out[4]);
		$display("test override done");
	endtask
	task automatic t_err;
		hit(5'h08);
		chk("nonfatal", 1'b1, err_nonfatal_out);
		chk("nonfatal_mode", 1'b1, run_mode_out);
		hit(5'h04);
		chk("nonfatal_clr", 1'b0, err_nonfatal_out);
		hit(5'h02);
		chk("fatal_flag", 1'b1, err_fatal_out);
		chk("fatal_mode", 1'b0, run_mode_out);
		chk("fatal_outs", 16'h0000, out_points_out);
		hit(5'h04);
		set_sw(`CSS_SW_PROG);
		set_sw(`CSS_SW_RUN);
		scan_end(2);
		chk("recovered", 1'b1, out_points_out[0]);
		$display("test errors done");
	endtask
	task automatic t_edit;
		edit_active_in = 1'b1;
		in_points_in = 16'h0000;
		scan_end(2);
		chk("edit_hold", 1'b1, out_points_out[0]);
		hit(5'h01);
		chk("edit_mode", 1'b0, run_mode_out);
		chk("edit_outs", 16'h0000, out_points_out);
		edit_active_in = 1'b0;
		$display("test edit done");
	endtask
	task automatic t_term;
		set_sw(`CSS_SW_TERM);
		pm_run_in = 1'b1;
		hit(5'h10);
		chk("term_run", 1'b1, run_mode_out);
		pm_run_in = 1'b0;
		hit(5'h10);
		chk("term_prog", 1'b0, run_mode_out);
		set_sw(`CSS_SW_PROG);
		pm_run_in = 1'b1;
		hit(5'h10);
		chk("cmd_ignored", 1'b0, run_mode_out);
		bus_local_in = 1'b0;
		bad = 1'b0;
		repeat (40) begin
			@(negedge ref_clk_in);
			bad = bad | (bus_req_out === 1'b1);
		end
		chk("bus_no_local", 1'b0, bad);
		$display("test terminal done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge ref_clk_in);
		nrst_in = 1'b1;
		@(negedge ref_clk_in);
		chk("rst_mode", 1'b0, run_mode_out);
		chk("rst_outs", 16'h0000, out_points_out);
		$display("test reset done");
		t_prog;
		t_run;
		t_force;
		t_ovr;
		t_err;
		t_edit;
		t_term;
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		n_fail++;
		print_verdict;
	end
endmodule

// file: sim/css_io_model.sv
// Far-side model: remote link master, backplane module and loop engine
`timescale 1ns/1ps
module css_io_model import css_pkg::*; #(
	parameter logic [15:0] RDATA = 16'h5AC3,
	parameter logic [15:0] REMOTE = 16'h3C96
) (
	input wire logic ref_clk_in,
	input wire css_seg_t seg_in,
	input wire logic bus_req_in,
	input wire logic bus_we_in,
	input wire logic loop_req_in,
	input wire logic [3:0] delay_in,
	output logic remote_valid_out,
	output logic [15:0] remote_data_out,
	output logic bus_done_out,
	output logic [15:0] bus_rdata_out,
	output logic loop_done_out
);
	logic [3:0] cnt;
	logic busy;
	assign busy = (bus_req_in || loop_req_in) && !bus_done_out && !loop_done_out;
	// Read data only valid while read phase requested
	assign bus_rdata_out = (bus_req_in && !bus_we_in) ? RDATA : ~RDATA;
	always @(negedge ref_clk_in) begin
		remote_valid_out <= (seg_in == st_special);
		remote_data_out <= (seg_in == st_special) ? REMOTE : ~remote_data_out;
		bus_done_out <= 1'b0;
		loop_done_out <= 1'b0;
		cnt <= busy ? cnt + 4'h1 : 4'h0;
		if (busy && cnt >= delay_in) begin
			bus_done_out <= bus_req_in;
			loop_done_out <= loop_req_in;
			cnt <= 4'h0;
		end
	end
endmodule
